//--- common/pnp_pkg.sv
// Operation
// [RULE1] bit 5 picks eeprom clock or gpio three
// [RULE2] bit 2 picks eeprom data or gpio four
// [RULE3] bit 1 picks eeprom select or gpio five
// [RULE4] medium bit 6: copper set, fiber cleared
// [RULE5] fiber bypasses line coding and scrambling
// [RULE6] software clears dsp control six bit 13
// [RULE7] next page bit 15: more pages follow
// [RULE8] bit 13 message page flag, resets one
// [RULE9] bit 12 comply flag, resets zero
// [RULE10] bit 11 inverts previous codeword toggle
// [RULE11] first next page inverts base bit 11
// [RULE12] bits 10:0 code field, resets 0x001
// [RULE13] reserved bits keep documented defaults
package pnp_pkg;
	localparam int unsigned PNP_ADR_W = 12;
	localparam int unsigned PNP_SYNC_STAGES = 2;
	// each register decodes at its own byte offset and uses the low half of the data bus
	localparam logic [7:0] PNP_IDX_PFS = 8'hd6;
	localparam logic [7:0] PNP_IDX_PMC = 8'hd8;
	localparam logic [7:0] PNP_IDX_NPT = 8'hdc;
	localparam logic [11:0] PNP_ADR_PFS = {4'h0, PNP_IDX_PFS};
	localparam logic [11:0] PNP_ADR_PMC = {4'h0, PNP_IDX_PMC};
	localparam logic [11:0] PNP_ADR_NPT = {4'h0, PNP_IDX_NPT};
	localparam logic [15:0] PNP_PFS_RST = 16'h0fff;
	localparam logic [15:0] PNP_PFS_WMASK = 16'h0fff;
	localparam logic [15:0] PNP_PMC_RST = 16'h00fe;
	localparam logic [15:0] PNP_PMC_WMASK = 16'h00cf;
	localparam logic [15:0] PNP_NPT_RST = 16'h2001;
	localparam int unsigned PNP_PFS_EECLK_BIT = 5;
	localparam int unsigned PNP_PFS_EEDAT_BIT = 2;
	localparam int unsigned PNP_PFS_EESEL_BIT = 1;
	localparam int unsigned PNP_PMC_COPPER_BIT = 6;
	localparam int unsigned PNP_NPT_MORE_BIT = 15;
	localparam int unsigned PNP_NPT_MSG_BIT = 13;
	localparam int unsigned PNP_NPT_COMPLY_BIT = 12;
	localparam int unsigned PNP_NPT_TOGGLE_BIT = 11;
	localparam int unsigned PNP_NPT_CODE_MSB = 10;
	localparam int unsigned PNP_SYM_W = 5;
endpackage

//--- core/pnp_pin_mux.sv
`timescale 1ns/1ns
module pnp_pin_mux #(
	parameter int unsigned NUM_PINS = 3
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// routing, one bit per pin, high selects the eeprom function
	input wire logic [NUM_PINS-1:0] route_eeprom,
	// eeprom side
	input wire logic [NUM_PINS-1:0] ee_out,
	input wire logic [NUM_PINS-1:0] ee_oe,
	output logic [NUM_PINS-1:0] ee_in,
	// gpio side
	input wire logic [NUM_PINS-1:0] gpio_out,
	input wire logic [NUM_PINS-1:0] gpio_oe,
	output logic [NUM_PINS-1:0] gpio_in,
	// shared pins
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe
);
	import pnp_pkg::*;

	if (NUM_PINS < 1 || NUM_PINS > 16) begin : g_bad_pins
		$error("pnp_pin_mux: NUM_PINS out of range");
	end

	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		logic [PNP_SYNC_STAGES-1:0] sync_reg;

		// first stage is read only by the second
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				sync_reg <= '0;
			end else begin
				sync_reg <= {sync_reg[PNP_SYNC_STAGES-2:0], pin_in[i]};
			end
		end

		// the unselected function sees a quiet low input so it cannot act on stray pin traffic
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				pin_out[i] <= 1'b0;
				pin_oe[i] <= 1'b0;
				ee_in[i] <= 1'b0;
				gpio_in[i] <= 1'b0;
			end else begin
				pin_out[i] <= route_eeprom[i] ? ee_out[i] : gpio_out[i];
				pin_oe[i] <= route_eeprom[i] ? ee_oe[i] : gpio_oe[i];
				ee_in[i] <= route_eeprom[i] & sync_reg[PNP_SYNC_STAGES-1];
				gpio_in[i] <= ~route_eeprom[i] & sync_reg[PNP_SYNC_STAGES-1];
			end
		end
	end
endmodule

//--- core/pnp_regs.sv
`timescale 1ns/1ns
module pnp_regs (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pnp_pkg::PNP_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// shared pins, index 0 clock, 1 data, 2 chip select
	input wire logic [2:0] pin_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe,
	// eeprom loader side
	input wire logic [2:0] ee_out,
	input wire logic [2:0] ee_oe,
	output logic [2:0] ee_in,
	// gpio side, index 0 line three, 1 line four, 2 line five
	input wire logic [2:0] gpio_out,
	input wire logic [2:0] gpio_oe,
	output logic [2:0] gpio_in,
	// port symbol path
	input wire logic [pnp_pkg::PNP_SYM_W-1:0] tx_coded_sym,
	input wire logic [pnp_pkg::PNP_SYM_W-1:0] tx_raw_sym,
	output logic [pnp_pkg::PNP_SYM_W-1:0] tx_line_sym,
	input wire logic [pnp_pkg::PNP_SYM_W-1:0] rx_decoded_sym,
	input wire logic [pnp_pkg::PNP_SYM_W-1:0] rx_raw_sym,
	output logic [pnp_pkg::PNP_SYM_W-1:0] rx_port_sym,
	output logic coding_bypass,
	// auto-negotiation engine
	input wire logic page_load,
	input wire logic page_more,
	input wire logic page_message,
	input wire logic page_comply,
	input wire logic [10:0] page_code,
	input wire logic cw_exchanged,
	input wire logic cw_toggle_bit,
	output logic [15:0] next_page_word
);
	import pnp_pkg::*;

	logic [15:0] pin_function_select_reg;
	logic [15:0] port_medium_config_reg;
	logic [15:0] next_page_transmit_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic fiber_reg;
	logic [PNP_SYM_W-1:0] tx_sym_reg;
	logic [PNP_SYM_W-1:0] rx_sym_reg;
	logic req;
	logic [15:0] byte_mask;
	logic [15:0] rd_word;
	logic [2:0] route_eeprom;

	assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign byte_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign route_eeprom = {pin_function_select_reg[PNP_PFS_EESEL_BIT],
		pin_function_select_reg[PNP_PFS_EEDAT_BIT],
		pin_function_select_reg[PNP_PFS_EECLK_BIT]};

	// one wait state; ack drops the cycle after it was given
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req;
		end
	end

	always_comb begin
		unique case (wb_adr_i)
			PNP_ADR_PFS: rd_word = pin_function_select_reg;
			PNP_ADR_PMC: rd_word = port_medium_config_reg;
			PNP_ADR_NPT: rd_word = next_page_transmit_reg;
			default: rd_word = 16'h0000;
		endcase
	end

	// unmapped reads return zero; upper half always reads zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			rdata_reg <= {16'h0000, rd_word};
		end
	end

	// only writable bits take data; reserved read-only bits hold their defaults
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_function_select_reg <= PNP_PFS_RST;
		end else if (req && wb_we_i && wb_adr_i == PNP_ADR_PFS) begin
			pin_function_select_reg <= (pin_function_select_reg & ~(PNP_PFS_WMASK & byte_mask)) |
				(wb_dat_i[15:0] & PNP_PFS_WMASK & byte_mask); // [RULE1] [RULE2] [RULE3] [RULE13]
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port_medium_config_reg <= PNP_PMC_RST;
		end else if (req && wb_we_i && wb_adr_i == PNP_ADR_PMC) begin
			port_medium_config_reg <= (port_medium_config_reg & ~(PNP_PMC_WMASK & byte_mask)) |
				(wb_dat_i[15:0] & PNP_PMC_WMASK & byte_mask); // [RULE4] [RULE13]
		end
	end

	// software has no write path here; the negotiation engine owns this word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			next_page_transmit_reg <= PNP_NPT_RST; // [RULE7] [RULE8] [RULE9] [RULE12]
		end else begin
			if (page_load) begin
				next_page_transmit_reg[PNP_NPT_MORE_BIT] <= page_more; // [RULE7]
				next_page_transmit_reg[PNP_NPT_MSG_BIT] <= page_message; // [RULE8]
				next_page_transmit_reg[PNP_NPT_COMPLY_BIT] <= page_comply; // [RULE9]
				next_page_transmit_reg[PNP_NPT_CODE_MSB:0] <= page_code; // [RULE12]
			end
			// base page exchange seeds the first next page, later exchanges keep alternating
			if (cw_exchanged) begin
				next_page_transmit_reg[PNP_NPT_TOGGLE_BIT] <= ~cw_toggle_bit; // [RULE10] [RULE11]
			end
		end
	end

	// medium choice registered once so both symbol paths switch on the same edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fiber_reg <= 1'b0;
		end else begin
			fiber_reg <= ~port_medium_config_reg[PNP_PMC_COPPER_BIT]; // [RULE4]
		end
	end

	// dsp control six is not cleared here; fiber users must do that themselves
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_sym_reg <= '0;
			rx_sym_reg <= '0;
		end else begin
			tx_sym_reg <= fiber_reg ? tx_raw_sym : tx_coded_sym; // [RULE5]
			rx_sym_reg <= fiber_reg ? rx_raw_sym : rx_decoded_sym; // [RULE5]
		end
	end

	pnp_pin_mux #(
		.NUM_PINS(3)
	) u_pin_mux (
		.clock(clock),
		.reset_n(reset_n),
		.route_eeprom(route_eeprom),
		.ee_out(ee_out),
		.ee_oe(ee_oe),
		.ee_in(ee_in),
		.gpio_out(gpio_out),
		.gpio_oe(gpio_oe),
		.gpio_in(gpio_in),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign coding_bypass = fiber_reg;
	assign tx_line_sym = tx_sym_reg;
	assign rx_port_sym = rx_sym_reg;
	assign next_page_word = next_page_transmit_reg;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_ack_after_req: assert property (req |=> wb_ack_o)
		else $error("request not acknowledged next cycle");

	a_eeclk_route: assert property ( // [RULE1]
		pin_function_select_reg[PNP_PFS_EECLK_BIT] && $stable(pin_function_select_reg)
		|=> pin_out[0] == $past(ee_out[0]) && pin_oe[0] == $past(ee_oe[0]))
		else $error("clock pin not routed to eeprom");

	a_gpio_three_route: assert property ( // [RULE1]
		!pin_function_select_reg[PNP_PFS_EECLK_BIT]
		|=> pin_out[0] == $past(gpio_out[0]) && !ee_in[0])
		else $error("clock pin not routed to gpio three");

	a_eedata_route: assert property ( // [RULE2]
		pin_function_select_reg[PNP_PFS_EEDAT_BIT]
		|=> pin_oe[1] == $past(ee_oe[1]) && !gpio_in[1])
		else $error("data pin routing wrong");

	a_eesel_route: assert property ( // [RULE3]
		!pin_function_select_reg[PNP_PFS_EESEL_BIT]
		|=> pin_out[2] == $past(gpio_out[2]) && pin_oe[2] == $past(gpio_oe[2]))
		else $error("select pin not routed to gpio five");

	a_medium_follows: assert property ( // [RULE4]
		$changed(port_medium_config_reg[PNP_PMC_COPPER_BIT])
		|=> coding_bypass != $past(port_medium_config_reg[PNP_PMC_COPPER_BIT]))
		else $error("bypass does not track medium bit");

	a_fiber_bypass: assert property ( // [RULE5]
		coding_bypass |=> tx_line_sym == $past(tx_raw_sym) && rx_port_sym == $past(rx_raw_sym))
		else $error("fiber mode still uses coded symbols");

	a_copper_coded: assert property ( // [RULE5]
		!coding_bypass |=> tx_line_sym == $past(tx_coded_sym))
		else $error("copper mode bypasses coding");

	a_npt_no_write: assert property ( // [RULE7]
		req && wb_we_i && !page_load && !cw_exchanged |=> $stable(next_page_transmit_reg))
		else $error("software write altered next page word");

	a_npt_fields_load: assert property ( // [RULE8]
		page_load |=> next_page_word[PNP_NPT_MSG_BIT] == $past(page_message)
		&& next_page_word[PNP_NPT_COMPLY_BIT] == $past(page_comply)
		&& next_page_word[PNP_NPT_CODE_MSB:0] == $past(page_code))
		else $error("next page fields not loaded");

	a_toggle_inverts: assert property ( // [RULE10]
		cw_exchanged |=> next_page_word[PNP_NPT_TOGGLE_BIT] == !$past(cw_toggle_bit))
		else $error("toggle bit not inverted");

	a_toggle_holds: assert property ( // [RULE11]
		!cw_exchanged |=> $stable(next_page_word[PNP_NPT_TOGGLE_BIT]))
		else $error("toggle bit changed without exchange");

	a_reserved_ro: assert property ( // [RULE13]
		pin_function_select_reg[15:12] == 4'h0 && port_medium_config_reg[15:8] == 8'h00
		&& port_medium_config_reg[5:4] == 2'h3 && next_page_transmit_reg[14] == 1'b0)
		else $error("reserved read-only bits changed");

	a_read_returns: assert property ( // [RULE12]
		req && !wb_we_i && wb_adr_i == PNP_ADR_NPT && !page_load && !cw_exchanged
		|=> wb_dat_o == {16'h0000, next_page_transmit_reg})
		else $error("next page readback wrong");

	// each pin checked for both functions in both directions
	a_eeclk_quiet: assert property ( // [RULE1]
		pin_function_select_reg[PNP_PFS_EECLK_BIT] |=> !gpio_in[0])
		else $error("gpio three sees clock pin traffic");

	a_gpio_three_oe: assert property ( // [RULE1]
		!pin_function_select_reg[PNP_PFS_EECLK_BIT] |=> pin_oe[0] == $past(gpio_oe[0]))
		else $error("clock pin enable not from gpio three");

	a_eedata_pin: assert property ( // [RULE2]
		pin_function_select_reg[PNP_PFS_EEDAT_BIT] |=> pin_out[1] == $past(ee_out[1]))
		else $error("data pin value not from eeprom");

	a_gpio_four_route: assert property ( // [RULE2]
		!pin_function_select_reg[PNP_PFS_EEDAT_BIT]
		|=> pin_out[1] == $past(gpio_out[1]) && pin_oe[1] == $past(gpio_oe[1]) && !ee_in[1])
		else $error("data pin not routed to gpio four");

	a_eesel_pin: assert property ( // [RULE3]
		pin_function_select_reg[PNP_PFS_EESEL_BIT]
		|=> pin_out[2] == $past(ee_out[2]) && pin_oe[2] == $past(ee_oe[2]) && !gpio_in[2])
		else $error("select pin not routed to eeprom");

	a_gpio_five_quiet: assert property ( // [RULE3]
		!pin_function_select_reg[PNP_PFS_EESEL_BIT] |=> !ee_in[2])
		else $error("eeprom sees select pin traffic");

	a_rx_coded: assert property ( // [RULE5]
		!coding_bypass |=> rx_port_sym == $past(rx_decoded_sym))
		else $error("copper mode bypasses decoding");

	a_more_pages_load: assert property ( // [RULE7]
		page_load |=> next_page_word[PNP_NPT_MORE_BIT] == $past(page_more))
		else $error("more pages flag not loaded");

	// a full write lands on writable bits while read-only bits keep their defaults
	a_select_write: assert property ( // [RULE13]
		req && wb_we_i && wb_adr_i == PNP_ADR_PFS && wb_sel_i[1:0] == 2'h3
		|=> pin_function_select_reg == (($past(wb_dat_i[15:0]) & PNP_PFS_WMASK) | (PNP_PFS_RST & ~PNP_PFS_WMASK)))
		else $error("select write did not land");

	a_medium_write: assert property ( // [RULE4] [RULE13]
		req && wb_we_i && wb_adr_i == PNP_ADR_PMC && wb_sel_i[1:0] == 2'h3
		|=> port_medium_config_reg == (($past(wb_dat_i[15:0]) & PNP_PMC_WMASK) | (PNP_PMC_RST & ~PNP_PMC_WMASK)))
		else $error("medium write did not land");

	a_ack_needs_req: assert property (!req |=> !wb_ack_o)
		else $error("ack without a request");

	a_unmapped_zero: assert property (
		req && !wb_we_i && wb_adr_i != PNP_ADR_PFS && wb_adr_i != PNP_ADR_PMC && wb_adr_i != PNP_ADR_NPT
		|=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	c_fiber_select: cover property (
		req && wb_we_i && wb_adr_i == PNP_ADR_PMC && wb_sel_i[0] && !wb_dat_i[PNP_PMC_COPPER_BIT]);

	c_gpio_route: cover property (!pin_function_select_reg[PNP_PFS_EECLK_BIT] ##1 pin_oe[0]);

	c_page_exchange: cover property (page_load ##1 cw_exchanged ##2 cw_exchanged);

	c_unmapped_read: cover property (req && !wb_we_i && rd_word == 16'h0000 ##1 wb_ack_o);

	c_copper_return: cover property (coding_bypass ##1 !coding_bypass);
endmodule

//--- dv/tb.sv
`timescale 1ns/1ns
module tb;
	import pnp_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat;
	logic ack, bypass;
	logic [2:0] pin_in = 3'h0, ee_out = 3'h0, ee_oe = 3'h0, gpio_out = 3'h0, gpio_oe = 3'h0;
	logic [2:0] pin_out, pin_oe, ee_in, gpio_in, m;
	logic [4:0] tx_coded = 5'h0, tx_raw = 5'h0, rx_dec = 5'h0, rx_raw = 5'h0, tx_line, rx_port;
	logic pg_load = 1'b0, pg_more = 1'b0, pg_msg = 1'b0, pg_comply = 1'b0, cw_ex = 1'b0, cw_tog = 1'b0;
	logic [10:0] pg_code = 11'h0;
	logic [15:0] npw, rd, exp;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;

	pnp_regs u_pnp_regs (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ee_out(ee_out), .ee_oe(ee_oe), .ee_in(ee_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .tx_coded_sym(tx_coded),
		.tx_raw_sym(tx_raw), .tx_line_sym(tx_line), .rx_decoded_sym(rx_dec), .rx_raw_sym(rx_raw),
		.rx_port_sym(rx_port), .coding_bypass(bypass), .page_load(pg_load), .page_more(pg_more),
		.page_message(pg_msg), .page_comply(pg_comply), .page_code(pg_code), .cw_exchanged(cw_ex),
		.cw_toggle_bit(cw_tog), .next_page_word(npw));

	always #25 clock = ~clock;

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		n_compared++;
		if (got !== want) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	// one classic cycle; the slave's ack latency is not assumed, the cycle ceiling ends a hang
	task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
		output logic [15:0] q);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {16'h0, d};
		sel <= s;
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		wb(1'b1, a, d, 4'h3, rd);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [15:0] want);
		wb(1'b0, a, 16'h0, 4'h3, rd);
		chk(rd, want);
	endtask

	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		chk(npw, 16'h2001);
		rchk(PNP_ADR_PFS, 16'h0fff);
		rchk(PNP_ADR_PMC, 16'h00fe);
		rchk(PNP_ADR_NPT, 16'h2001);
		rchk(12'h354, 16'h0000);
		wr(PNP_ADR_NPT, 16'h5ffe);
		rchk(PNP_ADR_NPT, 16'h2001);
		wr(PNP_ADR_PFS, 16'hffff);
		rchk(PNP_ADR_PFS, 16'h0fff);
		wr(PNP_ADR_PFS, 16'h0000);
		wb(1'b1, PNP_ADR_PFS, 16'hffff, 4'h1, rd);
		rchk(PNP_ADR_PFS, 16'h00ff);
		// every routing combination; stimulus differs per pass so a stuck mux shows
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			wr(PNP_ADR_PFS, 16'h0fd9 | {10'h0, m[0], 2'h0, m[1], m[2], 1'b0});
			pin_in <= m ^ 3'h5;
			ee_out <= m ^ 3'h4;
			ee_oe <= m ^ 3'h6;
			gpio_out <= m ^ 3'h3;
			gpio_oe <= m ^ 3'h1;
			repeat (4) @(posedge clock);
			#1;
			chk(16'(pin_out), 16'((m & ee_out) | (~m & gpio_out)));
			chk(16'(pin_oe), 16'((m & ee_oe) | (~m & gpio_oe)));
			chk(16'(ee_in), 16'(m & pin_in));
			chk(16'(gpio_in), 16'(~m & pin_in));
		end
		for (int p = 0; p < 2; p++) begin
			wr(PNP_ADR_PMC, p ? 16'hffff : 16'h0000);
			// with fiber chosen, software also clears the dsp control bit, which lies outside this block
			if (p == 0) begin
				wr(12'h734, 16'h0000);
				rchk(12'h734, 16'h0000);
			end
			rchk(PNP_ADR_PMC, p ? 16'h00ff : 16'h0030);
			tx_coded <= 5'h0a ^ 5'(p);
			tx_raw <= 5'h15 ^ 5'(p);
			rx_dec <= 5'h03 ^ 5'(p);
			rx_raw <= 5'h1c ^ 5'(p);
			repeat (3) @(posedge clock);
			#1;
			chk(16'(bypass), p ? 16'h0 : 16'h1);
			chk(16'(tx_line), 16'(p ? tx_coded : tx_raw));
			chk(16'(rx_port), 16'(p ? rx_dec : rx_raw));
		end
		// first pass carries the base codeword, the second a next page
		for (int k = 0; k < 2; k++) begin
			@(posedge clock);
			pg_load <= 1'b1;
			pg_more <= ~k[0];
			pg_msg <= k[0];
			pg_comply <= ~k[0];
			pg_code <= 11'h7aa ^ 11'(k);
			cw_ex <= 1'b1;
			cw_tog <= ~k[0];
			@(posedge clock);
			pg_load <= 1'b0;
			cw_ex <= 1'b0;
			@(posedge clock);
			#1;
			exp = {pg_more, 1'b0, pg_msg, pg_comply, ~cw_tog, pg_code};
			chk(npw, exp);
			rchk(PNP_ADR_NPT, exp);
		end
		wrap_up();
	end
endmodule
